/* File: foa_pkg.sv */
// Purpose: shared constants and types of the four operand arithmetic unit
// Assumes: one 10 MHz clock, Avalon-MM register slave
// Notes: register offsets are byte addresses

package foa_pkg;

  localparam int DW = 16;
  localparam int IW = 48;
  localparam int AW = 5;
  localparam int BNW = 3;
  localparam int NLIVE = 8;
  localparam int NOPND = 4;
  localparam int NOPR = 3;
  localparam int OPR_W = 2;
  localparam int OPND_W = DW + BNW + 1;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] ADR_CTRL = 5'h00;
  localparam logic [AW-1:0] ADR_OPER = 5'h04;
  localparam logic [AW-1:0] ADR_OPND0 = 5'h08;
  localparam logic [AW-1:0] OPND_STEP = 5'h04;
  localparam logic [AW-1:0] ADR_RESULT = 5'h18;
  localparam logic [AW-1:0] ADR_STATUS = 5'h1c;

  localparam int CTRL_ZERO_BIT = 0;
  localparam int CTRL_DEC_LSB = 1;
  localparam int OPER_OP_LSB = 0;
  localparam int OPER_PRIO_LSB = 8;
  localparam int ST_ZDIV = 0;
  localparam int ST_OVP = 1;
  localparam int ST_OVN = 2;
  localparam int ST_ACT = 3;
  localparam int ST_BUSY = 4;

  localparam logic [1:0] PRIO_HIGH = 2'h0;
  localparam logic [1:0] PRIO_MED = 2'h1;
  localparam logic [1:0] PRIO_LOW = 2'h2;
  localparam logic [1:0] STEP_LAST = 2'h2;

  localparam logic signed [DW-1:0] SAT_MAX = 16'sh7fff;
  localparam logic signed [DW-1:0] SAT_MIN = 16'sh8000;
  localparam logic signed [IW-1:0] LIM_MAX = 48'sh0000_0000_7fff;
  localparam logic signed [IW-1:0] LIM_MIN = 48'shffff_ffff_8000;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {FOA_ADD, FOA_SUB, FOA_MUL, FOA_DIV} foa_op_t;

  typedef enum logic [1:0] {FOA_IDLE, FOA_EVAL, FOA_FINISH} foa_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [AW-1:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } foa_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } foa_avs_rsp_t;

  typedef struct packed {
    logic zero_div;
    logic ovf_pos;
    logic ovf_neg;
  } foa_err_t;

  typedef struct packed {
    logic live;
    logic [BNW-1:0] blk;
    logic [DW-1:0] value;
  } foa_opnd_t;

  typedef struct packed {
    foa_avs_rsp_t rsp;
    logic zero_on_dis;
    logic [1:0] decimals;
    foa_op_t [NOPR-1:0] opr;
    logic [NOPR-1:0][1:0] prio;
    foa_opnd_t [NOPND-1:0] opnd;
    logic en_q;
    logic active;
    foa_state_t state;
    logic [1:0] step;
    logic [NOPND-1:0][IW-1:0] val;
    logic [NOPND-1:0][1:0] grp;
    logic dz;
    logic upd;
    logic [DW-1:0] result;
    foa_err_t err;
  } foa_st_t;

  function automatic logic [AW-1:0] opnd_adr(input int i);
    return AW'(ADR_OPND0 + OPND_STEP * i);
  endfunction

endpackage

/* File: foa_opcalc.sv */
// Purpose: one arithmetic operation on two wide signed values
// Assumes: inputs come from registered state
// Notes: division rounds half away from zero

module foa_opcalc
  import foa_pkg::*;
(
  // operation
  input foa_pkg::foa_op_t op,
  input wire logic signed [foa_pkg::IW-1:0] a,
  input wire logic signed [foa_pkg::IW-1:0] b,
  // answer
  output logic signed [foa_pkg::IW-1:0] res,
  output logic dz
);

  function automatic logic signed [IW-1:0] mag(input logic signed [IW-1:0] v);
    return (v < 0) ? -v : v;
  endfunction

  always_comb begin
    logic signed [2*IW-1:0] prod;
    logic signed [IW-1:0] q;
    logic signed [IW-1:0] r;
    prod = '0;
    q = '0;
    r = '0;
    dz = 1'b0;
    res = '0;
    case (op)
      FOA_ADD: res = a + b;
      FOA_SUB: res = a - b;
      FOA_MUL: begin
        prod = a * b;
        res = prod[IW-1:0];
      end
      default: begin
        if (b == '0) begin
          dz = 1'b1;
        end else begin
          q = a / b;
          r = a % b;
          // nearest integer, ties away from zero
          if ((mag(r) <<< 1) >= mag(b)) begin
            q = ((a < 0) != (b < 0)) ? q - 48'sh1 : q + 48'sh1;
          end
          res = q;
        end
      end
    endcase
  end

endmodule

/* File: foa_sat.sv */
// Purpose: clamp a wide result into 16 bits and classify errors
// Assumes: dz_in is sticky over one evaluation
// Notes: zero division outranks overflow

module foa_sat
  import foa_pkg::*;
(
  // wide value
  input wire logic signed [foa_pkg::IW-1:0] v,
  input wire logic dz_in,
  // clamped value
  output logic [foa_pkg::DW-1:0] q,
  output foa_pkg::foa_err_t err
);

  always_comb begin
    err = '0;
    q = v[DW-1:0];
    if (dz_in) begin
      q = SAT_MAX;
      err.zero_div = 1'b1;
    end else if (v > LIM_MAX) begin
      q = SAT_MAX;
      err.ovf_pos = 1'b1;
    end else if (v < LIM_MIN) begin
      q = SAT_MIN;
      err.ovf_neg = 1'b1;
    end
  end

endmodule

/* File: foa_unit.sv */
// Purpose: four operand arithmetic unit with Avalon-MM registers
// Assumes: en and live values come from logic on clk_sys
// Notes: one program cycle is five clocks from start to update
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.

module foa_unit
  import foa_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // register bus
  input foa_pkg::foa_avs_req_t req,
  output foa_pkg::foa_avs_rsp_t rsp,
  // activation and live operand sources
  input wire logic en,
  input wire logic [foa_pkg::NLIVE-1:0][foa_pkg::DW-1:0] live_value,
  // result and errors
  output logic [foa_pkg::DW-1:0] result_output,
  output foa_pkg::foa_err_t err
);

  foa_st_t s;
  foa_st_t next_s;

  logic [1:0] sel;
  foa_op_t op_sel;
  logic signed [IW-1:0] op_a;
  logic signed [IW-1:0] op_b;
  logic signed [IW-1:0] op_res;
  logic op_dz;
  logic [DW-1:0] sat_q;
  foa_err_t sat_err;

  // ---------------------------------------------------------------
  // operator selection by priority
  // ---------------------------------------------------------------
  function automatic logic [1:0] pick_op(input logic [NOPR-1:0][1:0] pr,
                                         input logic [1:0] st);
    logic [1:0] k;
    k = st;
    for (int i = 0; i < NOPR; i++) begin
      if (pr[i] == st) begin
        k = 2'(i);
      end
    end
    return k;
  endfunction

  assign sel = pick_op(s.prio, s.step);
  assign op_sel = s.opr[sel];
  // operator i joins slot i and slot i+1
  assign op_a = $signed(s.val[sel]);
  assign op_b = $signed(s.val[sel + 2'h1]);

  foa_opcalc u_calc (
    .op(op_sel),
    .a(op_a),
    .b(op_b),
    .res(op_res),
    .dz(op_dz)
  );

  foa_sat u_sat (
    .v($signed(s.val[0])),
    .dz_in(s.dz),
    .q(sat_q),
    .err(sat_err)
  );

  // ---------------------------------------------------------------
  // write lane merge
  // ---------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] rd;
    logic [31:0] w;
    logic rise;
    logic [DW-1:0] opv;
    logic [1:0] ga;
    logic [1:0] gb;
    rd = '0;
    w = '0;
    rise = 1'b0;
    opv = '0;
    ga = '0;
    gb = '0;
    next_s = s;
    next_s.upd = 1'b0;

    // register read image
    if (req.address == ADR_CTRL) begin
      rd[CTRL_ZERO_BIT] = s.zero_on_dis;
      rd[CTRL_DEC_LSB +: 2] = s.decimals;
    end else if (req.address == ADR_OPER) begin
      for (int i = 0; i < NOPR; i++) begin
        rd[OPER_OP_LSB + OPR_W*i +: OPR_W] = s.opr[i];
        rd[OPER_PRIO_LSB + OPR_W*i +: OPR_W] = s.prio[i];
      end
    end else if (req.address == ADR_RESULT) begin
      rd[DW-1:0] = s.result;
    end else if (req.address == ADR_STATUS) begin
      rd[ST_ZDIV] = s.err.zero_div;
      rd[ST_OVP] = s.err.ovf_pos;
      rd[ST_OVN] = s.err.ovf_neg;
      rd[ST_ACT] = s.active;
      rd[ST_BUSY] = (s.state != FOA_IDLE);
    end else begin
      for (int i = 0; i < NOPND; i++) begin
        if (req.address == opnd_adr(i)) begin
          rd[OPND_W-1:0] = s.opnd[i];
        end
      end
    end

    // bus handshake: one wait cycle, then a one cycle answer
    next_s.rsp.waitrequest = 1'b1;
    if ((req.read || req.write) && s.rsp.waitrequest) begin
      next_s.rsp.waitrequest = 1'b0;
      next_s.rsp.readdata = rd;
    end

    if (req.write && !s.rsp.waitrequest) begin
      w = be_merge(rd, req.writedata, req.byteenable);
      if (req.address == ADR_CTRL) begin
        next_s.zero_on_dis = w[CTRL_ZERO_BIT];
        // display only, not read by the datapath
        next_s.decimals = w[CTRL_DEC_LSB +: 2];
      end else if (req.address == ADR_OPER) begin
        for (int i = 0; i < NOPR; i++) begin
          next_s.opr[i] = foa_op_t'(w[OPER_OP_LSB + OPR_W*i +: OPR_W]);
          next_s.prio[i] = w[OPER_PRIO_LSB + OPR_W*i +: OPR_W];
        end
      end else begin
        for (int i = 0; i < NOPND; i++) begin
          if (req.address == opnd_adr(i)) begin
            next_s.opnd[i] = w[OPND_W-1:0];
          end
        end
      end
    end

    // activation and evaluation
    rise = en && !s.en_q;
    next_s.en_q = en;
    if (!en) begin
      next_s.active = 1'b0;
      next_s.state = FOA_IDLE;
      if (s.zero_on_dis) begin
        next_s.result = '0;
      end
    end else begin
      if (rise) begin
        next_s.active = 1'b1;
      end
      case (s.state)
        FOA_IDLE: begin
          if (s.active || rise) begin
            for (int j = 0; j < NOPND; j++) begin
              opv = s.opnd[j].live ? live_value[s.opnd[j].blk]
                                   : s.opnd[j].value;
              next_s.val[j] = IW'($signed(opv));
              next_s.grp[j] = 2'(j);
            end
            next_s.dz = 1'b0;
            next_s.step = PRIO_HIGH;
            next_s.state = FOA_EVAL;
          end
        end
        FOA_EVAL: begin
          // both groups next to the operator become one
          ga = s.grp[sel];
          gb = s.grp[sel + 2'h1];
          for (int j = 0; j < NOPND; j++) begin
            if (s.grp[j] == ga || s.grp[j] == gb) begin
              next_s.val[j] = op_res;
              next_s.grp[j] = ga;
            end
          end
          next_s.dz = s.dz | op_dz;
          next_s.step = s.step + 2'h1;
          if (s.step == STEP_LAST) begin
            next_s.state = FOA_FINISH;
          end
        end
        default: begin
          next_s.result = sat_q;
          next_s.err = sat_err;
          next_s.upd = 1'b1;
          next_s.state = FOA_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.rsp.waitrequest <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign rsp = s.rsp;
  assign result_output = s.result;
  assign err = s.err;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  logic cfg_ok;
  logic signed [IW-1:0] rnd_err;
  logic signed [IW-1:0] rnd_abs;
  logic signed [IW-1:0] b_abs;

  assign cfg_ok = (s.prio[0] != s.prio[1]) && (s.prio[0] != s.prio[2])
                  && (s.prio[1] != s.prio[2]) && (s.prio[0] <= PRIO_LOW)
                  && (s.prio[1] <= PRIO_LOW) && (s.prio[2] <= PRIO_LOW);
  assign rnd_err = op_a - op_res * op_b;
  assign rnd_abs = (rnd_err < 0) ? -rnd_err : rnd_err;
  assign b_abs = (op_b < 0) ? -op_b : op_b;

  sequence s_fin;
    s.state == FOA_FINISH && ce && en;
  endsequence

  sequence s_run4;
    (ce && en)[*4];
  endsequence

  property p_start;
    (ce && en && !s.en_q) |=> s.active && s.state == FOA_EVAL;
  endproperty
  a_start: assert property (p_start) else $error("no start on enable edge");

  property p_add;
    (s.state == FOA_EVAL && op_sel == FOA_ADD) |-> op_res == op_a + op_b;
  endproperty
  a_add: assert property (p_add) else $error("add decode wrong");

  property p_prio;
    (s.state == FOA_EVAL && cfg_ok) |-> s.prio[sel] == s.step;
  endproperty
  a_prio: assert property (p_prio) else $error("operation out of order");

  property p_round;
    (s.state == FOA_EVAL && op_sel == FOA_DIV && op_b != '0)
      |-> (rnd_abs <<< 1) <= b_abs;
  endproperty
  a_round: assert property (p_round) else $error("quotient not nearest");

  property p_dz;
    s_fin ##0 s.dz |=> result_output == SAT_MAX && err.zero_div;
  endproperty
  a_dz: assert property (p_dz) else $error("zero division not clamped");

  property p_pos;
    s_fin ##0 (!s.dz && $signed(s.val[0]) > LIM_MAX)
      |=> result_output == SAT_MAX && err.ovf_pos;
  endproperty
  a_pos: assert property (p_pos) else $error("positive overflow not clamped");

  property p_neg;
    s_fin ##0 (!s.dz && $signed(s.val[0]) < LIM_MIN)
      |=> result_output == SAT_MIN && err.ovf_neg;
  endproperty
  a_neg: assert property (p_neg) else $error("negative overflow not clamped");

  property p_zero;
    (ce && !en && s.zero_on_dis) |=> result_output == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("result not zeroed");

  property p_hold;
    (ce && !en && !s.zero_on_dis) |=> $stable(result_output);
  endproperty
  a_hold: assert property (p_hold) else $error("result not held");

  property p_period;
    (s.state == FOA_IDLE && s.active && ce && en) ##1 s_run4 |=> s.upd;
  endproperty
  a_period: assert property (p_period) else $error("no update in cycle");

  property p_sub;
    (s.state == FOA_EVAL && op_sel == FOA_SUB) |-> op_res == op_a - op_b;
  endproperty
  a_sub: assert property (p_sub) else $error("subtract decode wrong");

  property p_dzflag;
    (ce && s.state == FOA_EVAL && op_sel == FOA_DIV && op_b == '0) |=> s.dz;
  endproperty
  a_dzflag: assert property (p_dzflag) else $error("zero division not flagged");

  property p_load;
    (ce && en && s.state == FOA_IDLE && (s.active || !s.en_q) && !s.opnd[0].live)
      |=> s.val[0][DW-1:0] == $past(s.opnd[0].value);
  endproperty
  a_load: assert property (p_load) else $error("constant operand not latched");

  property p_live;
    (ce && en && s.state == FOA_IDLE && (s.active || !s.en_q) && s.opnd[1].live)
      |=> s.val[1][DW-1:0] == $past(live_value[s.opnd[1].blk]);
  endproperty
  a_live: assert property (p_live) else $error("live operand not latched");

endmodule

/* File: foa_live_src.sv */
// Purpose: model of the other function blocks that feed live operand values
// Assumes: same clock domain as the unit, block number is the array index
// Notes: values change only when the bench asks, at a rising edge

module foa_live_src
  import foa_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // update from bench
  input wire logic set_live,
  input wire logic [foa_pkg::BNW-1:0] live_idx,
  input wire logic [foa_pkg::DW-1:0] live_val,
  // live values seen by the unit
  output logic [foa_pkg::NLIVE-1:0][foa_pkg::DW-1:0] live_value
);
  timeunit 1ns;
  timeprecision 1ns;

  // ---------------------------------------------------------------
  // live value table
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      live_value <= '0;
    end else if (set_live) begin
      live_value[live_idx] <= live_val;
    end
  end
endmodule

/* File: testbench.sv */
// Purpose: self-checking bench of the four operand arithmetic unit
// Assumes: expectations worked out by hand from the operand values
// Notes: each scenario is one task; operands 1 and 3..4 are constants

module testbench
  import foa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_sys;
  logic nrst;
  logic ce;
  foa_avs_req_t req;
  foa_avs_rsp_t rsp;
  logic en;
  logic [NLIVE-1:0][DW-1:0] live_value;
  logic [DW-1:0] result_output;
  foa_err_t err;
  logic set_live;
  logic [BNW-1:0] live_idx;
  logic [DW-1:0] live_val;
  logic zmode;
  int err_count;
  int check_count;

  foa_unit i_foa_unit (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .req(req), .rsp(rsp), .en(en),
    .live_value(live_value), .result_output(result_output), .err(err));

  foa_live_src i_foa_live_src (.clk_sys(clk_sys), .nrst(nrst), .set_live(set_live),
    .live_idx(live_idx), .live_val(live_val), .live_value(live_value));

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_res(input logic [15:0] g, input logic [15:0] e);
    chk_w({16'h0, g}, {16'h0, e});
  endtask

  task automatic chk_err(input foa_err_t g, input logic [2:0] e);
    chk_w({29'h0, g}, {29'h0, e});
  endtask

  // ---------------------------------------------------------------
  // register bus master
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [AW-1:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    req <= '{read: ~wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge clk_sys);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 20);
    q = rsp.readdata;
    req <= '0;
    if (rsp.waitrequest !== 1'b0) begin
      err_count++;
      complete_run();
    end
  endtask

  task automatic wreg(input logic [AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // one full evaluation, then disable and look at the held or zeroed value
  task automatic eval(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c,
                      input logic [15:0] d, input logic [3:0] bsel, input foa_op_t o1,
                      input foa_op_t o2, input foa_op_t o3, input logic [5:0] pr,
                      input logic [15:0] ex, input logic [2:0] ee);
    wreg(ADR_OPND0, {16'h0, a});
    wreg(ADR_OPND0 + 5'h04, {12'h0, bsel, b});
    wreg(ADR_OPND0 + 5'h08, {16'h0, c});
    wreg(ADR_OPND0 + 5'h0c, {16'h0, d});
    wreg(ADR_OPER, {18'h0, pr, 2'h0, o3, o2, o1});
    @(posedge clk_sys);
    en <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk_res(result_output, ex);
    chk_err(err, ee);
    en <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk_res(result_output, zmode ? 16'h0 : ex);
    chk_err(err, ee);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    chk_res(result_output, 16'h0);
    chk_err(err, 3'h0);
    bus(1'b0, ADR_OPER, 32'h0, q);
    chk_w(q, 32'h0);
    wreg(ADR_RESULT, 32'h1234);
    bus(1'b0, ADR_RESULT, 32'h0, q);
    chk_w(q, 32'h0);
  endtask

  task automatic t_examples();
    eval(12, 6, 3, 1, 4'h0, FOA_ADD, FOA_DIV, FOA_SUB, 6'h21, 13, 3'h0);
    eval(2, 3, 1, 4, 4'h0, FOA_ADD, FOA_MUL, FOA_ADD, 6'h06, 17, 3'h0);
    eval(100, 25, 2, 1, 4'h0, FOA_SUB, FOA_DIV, FOA_ADD, 6'h18, 25, 3'h0);
    wreg(ADR_CTRL, 32'h6);
    eval(12, 6, 3, 1, 4'h0, FOA_ADD, FOA_DIV, FOA_SUB, 6'h21, 13, 3'h0);
    wreg(ADR_CTRL, 32'h0);
  endtask

  task automatic t_ops();
    eval(7, 2, 0, 0, 4'h0, FOA_ADD, FOA_ADD, FOA_ADD, 6'h24, 9, 3'h0);
    eval(7, 2, 0, 0, 4'h0, FOA_SUB, FOA_ADD, FOA_ADD, 6'h24, 5, 3'h0);
    eval(7, 2, 0, 0, 4'h0, FOA_MUL, FOA_ADD, FOA_ADD, 6'h24, 14, 3'h0);
    eval(7, 2, 0, 0, 4'h0, FOA_DIV, FOA_ADD, FOA_ADD, 6'h24, 4, 3'h0);
    eval(-7, 2, 0, 0, 4'h0, FOA_DIV, FOA_ADD, FOA_ADD, 6'h24, -4, 3'h0);
    eval(9, 1, 1, 0, 4'h0, FOA_MUL, FOA_MUL, FOA_ADD, 6'h24, 9, 3'h0);
  endtask

  task automatic t_sat();
    eval(32767, 1, 0, 0, 4'h0, FOA_ADD, FOA_ADD, FOA_ADD, 6'h24, 32767, 3'h2);
    eval(-32768, 1, 0, 0, 4'h0, FOA_SUB, FOA_ADD, FOA_ADD, 6'h24, -32768, 3'h1);
    eval(5, 0, 0, 0, 4'h0, FOA_DIV, FOA_ADD, FOA_ADD, 6'h24, 32767, 3'h4);
    eval(200, 200, 0, 0, 4'h0, FOA_MUL, FOA_ADD, FOA_ADD, 6'h24, 32767, 3'h2);
    eval(-200, 200, 0, 0, 4'h0, FOA_MUL, FOA_ADD, FOA_ADD, 6'h24, -32768, 3'h1);
    eval(300, 300, 10, 0, 4'h0, FOA_MUL, FOA_DIV, FOA_ADD, 6'h24, 9000, 3'h0);
  endtask

  task automatic t_zero();
    wreg(ADR_CTRL, 32'h1);
    zmode = 1'b1;
    eval(2, 3, 1, 4, 4'h0, FOA_ADD, FOA_MUL, FOA_ADD, 6'h06, 17, 3'h0);
    wreg(ADR_CTRL, 32'h0);
    zmode = 1'b0;
  endtask

  task automatic t_live();
    @(posedge clk_sys);
    set_live <= 1'b1;
    live_idx <= 3'h5;
    live_val <= 16'h0064;
    @(posedge clk_sys);
    set_live <= 1'b0;
    eval(1, 0, 0, 0, 4'hd, FOA_ADD, FOA_ADD, FOA_ADD, 6'h24, 101, 3'h0);
  endtask

  // status bits, then a start held off by a low clock enable
  task automatic t_status();
    logic [31:0] q;
    eval(5, 0, 0, 0, 4'h0, FOA_DIV, FOA_ADD, FOA_ADD, 6'h24, 16'h7fff, 3'h4);
    bus(1'b0, ADR_STATUS, 32'h0, q);
    chk_w(q, 32'h1);
    wreg(ADR_OPND0 + 5'h04, 32'h2);
    @(posedge clk_sys);
    ce <= 1'b0;
    en <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk_res(result_output, 16'h7fff);
    ce <= 1'b1;
    repeat (12) @(posedge clk_sys);
    chk_res(result_output, 16'h0003);
    chk_err(err, 3'h0);
    bus(1'b0, ADR_STATUS, 32'h0, q);
    chk_w(q & 32'h8, 32'h8);
    en <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    en = 1'b0;
    req = '0;
    set_live = 1'b0;
    live_idx = '0;
    live_val = '0;
    zmode = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_examples();
    t_ops();
    t_sat();
    t_zero();
    t_live();
    t_status();
    complete_run();
  end
endmodule
